// ### hdl/pdr_port_debug_regs.sv
// port direction, software breakpoint and debug scratch registers on apb
//
// What this block does
// - direction one drives output data on pin
// - direction zero releases pin to high impedance
// - seven independent direction bits, six down to zero
// - reserved bits always read as zero
// - writing break bit one triggers emulation breakpoint
// - break bit feeds emulation input, self-clears
// - reading the break bit returns zero
// - breakpoint register cleared on ordinary reset only, not on power-on or tap reset
// - scratch registers cleared on power-on or tap reset
// - scratch registers freely read and written
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pdr_port_debug_regs
    import pdr_pkg::*;
(
    // clock and resets
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic por_in,
    input wire logic tap_test_logic_reset_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [DATA_W-1:0] pwdata_in,
    output logic [DATA_W-1:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // port pins
    input wire logic [PIN_COUNT-1:0] port_output_data_in,
    output logic [PIN_COUNT-1:0] port_pin_out,
    output logic [PIN_COUNT-1:0] port_pin_oe_out,
    output logic [PIN_COUNT-1:0] port_pin_direction_out,
    // emulation block
    output logic emulation_soft_break_out
);

    // address decode shared by the write and read paths
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        reg_hit = (addr == {idx[5:0], 2'b00});
    endfunction : reg_hit

    // state
    logic [PIN_COUNT-1:0] port_pin_direction_ff;
    logic soft_breakpoint_trigger_ff;
    logic [SCR_W-1:0] scratch_zero_bits_ff;
    logic [SCR_W-1:0] scratch_one_bits_ff;
    logic [DATA_W-1:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;

    // bus phase decode
    logic setup_phase;
    logic access_done;
    logic wr_done;
    logic hit_dir;
    logic hit_brk;
    logic hit_scr0;
    logic hit_scr1;
    logic hit_any;
    logic scratch_clear;
    logic [DATA_W-1:0] nxt_prdata;

    assign setup_phase = psel_in & ~penable_in;
    assign access_done = psel_in & penable_in & pready_ff;
    assign wr_done = access_done & pwrite_in;
    assign hit_dir = reg_hit(paddr_in, REG_DIR_IDX);
    assign hit_brk = reg_hit(paddr_in, REG_BRK_IDX);
    assign hit_scr0 = reg_hit(paddr_in, REG_SCR0_IDX);
    assign hit_scr1 = reg_hit(paddr_in, REG_SCR1_IDX);
    assign hit_any = hit_dir | hit_brk | hit_scr0 | hit_scr1;
    assign scratch_clear = por_in | tap_test_logic_reset_in;

    // ready for exactly the one access cycle after setup: zero wait states
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup_phase;
            pslverr_ff <= setup_phase & ~hit_any;
        end
    end

    // direction register, only the seven pin bits exist
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            port_pin_direction_ff <= DIR_RESET;
        end else if (wr_done && hit_dir) begin
            port_pin_direction_ff <= pwdata_in[PIN_COUNT-1:0];
        end
    end

    // breakpoint strobe: one cycle high, then clears by itself
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            soft_breakpoint_trigger_ff <= BRK_RESET;
        end else begin
            soft_breakpoint_trigger_ff <= wr_done & hit_brk & pwdata_in[BRK_BIT];
        end
    end

    // scratch registers survive ordinary resets, only por or tap reset clears
    always_ff @(posedge core_clk_in) begin
        if (scratch_clear) begin
            scratch_zero_bits_ff <= SCR_RESET;
        end else if (wr_done && hit_scr0) begin
            scratch_zero_bits_ff <= pwdata_in[SCR_W-1:0];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (scratch_clear) begin
            scratch_one_bits_ff <= SCR_RESET;
        end else if (wr_done && hit_scr1) begin
            scratch_one_bits_ff <= pwdata_in[SCR_W-1:0];
        end
    end

    // read mux, evaluated in the setup cycle
    always_comb begin
        nxt_prdata = READ_ZERO;
        if (hit_dir) begin
            nxt_prdata[PIN_COUNT-1:0] = port_pin_direction_ff;
        end else if (hit_scr0) begin
            nxt_prdata[SCR_W-1:0] = scratch_zero_bits_ff;
        end else if (hit_scr1) begin
            nxt_prdata[SCR_W-1:0] = scratch_one_bits_ff;
        end
        // break register reads all zero, the strobe is never visible
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            prdata_ff <= READ_ZERO;
        end else if (setup_phase && !pwrite_in) begin
            prdata_ff <= nxt_prdata;
        end else if (access_done) begin
            prdata_ff <= READ_ZERO;
        end
    end

    // pin drivers
    pdr_pin_drive u_pin_drive (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .direction_in(port_pin_direction_ff),
        .port_output_data_in(port_output_data_in),
        .pin_out(port_pin_out),
        .pin_oe_out(port_pin_oe_out)
    );

    // outputs
    assign prdata_out = prdata_ff;
    assign pready_out = pready_ff;
    assign pslverr_out = pslverr_ff;
    assign port_pin_direction_out = port_pin_direction_ff;
    assign emulation_soft_break_out = soft_breakpoint_trigger_ff;

    // checks

    property p_driven_pin_data;
        @(posedge core_clk_in) disable iff (reset_in)
        !$past(reset_in) |->
            ((port_pin_out & port_pin_oe_out) == ($past(port_output_data_in) & port_pin_oe_out));
    endproperty
    a_driven_pin_data: assert property (p_driven_pin_data)
        else $error("driven pin does not carry output data");

    property p_released_pin;
        @(posedge core_clk_in) disable iff (reset_in)
        !$past(reset_in) |->
            (port_pin_oe_out == $past(port_pin_direction_ff)) && ((port_pin_out & ~port_pin_oe_out) == '0);
    endproperty
    a_released_pin: assert property (p_released_pin)
        else $error("pin enable does not follow direction bit");

    property p_dir_write;
        @(posedge core_clk_in) disable iff (reset_in)
        (wr_done && hit_dir) |=> (port_pin_direction_out == $past(pwdata_in[PIN_COUNT-1:0]))
            ##1 (port_pin_oe_out == $past(port_pin_direction_out));
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("direction write not applied per pin");

    property p_dir_read_reserved;
        @(posedge core_clk_in) disable iff (reset_in)
        (access_done && !pwrite_in && (hit_dir || hit_scr0 || hit_scr1)) |->
            (prdata_out[DATA_W-1:SCR_W] == '0) && (!hit_dir || prdata_out[SCR_W-1:PIN_COUNT] == '0);
    endproperty
    a_dir_read_reserved: assert property (p_dir_read_reserved)
        else $error("reserved bits read non-zero");

    property p_break_fires;
        @(posedge core_clk_in) disable iff (reset_in)
        (wr_done && hit_brk && pwdata_in[BRK_BIT]) |=> emulation_soft_break_out;
    endproperty
    a_break_fires: assert property (p_break_fires)
        else $error("break write did not reach emulation block");

    property p_break_self_clear;
        @(posedge core_clk_in) disable iff (reset_in)
        emulation_soft_break_out |=> !emulation_soft_break_out;
    endproperty
    a_break_self_clear: assert property (p_break_self_clear)
        else $error("break strobe did not clear itself");

    property p_break_reads_zero;
        @(posedge core_clk_in) disable iff (reset_in)
        (access_done && !pwrite_in && hit_brk) |-> (prdata_out == '0);
    endproperty
    a_break_reads_zero: assert property (p_break_reads_zero)
        else $error("break register read non-zero");

    property p_break_reset;
        @(posedge core_clk_in) disable iff (1'b0)
        reset_in |=> !emulation_soft_break_out && (port_pin_direction_out == DIR_RESET);
    endproperty
    a_break_reset: assert property (p_break_reset)
        else $error("break or direction not cleared by reset");

    property p_scratch_clear;
        @(posedge core_clk_in) disable iff (1'b0)
        scratch_clear |=> (scratch_zero_bits_ff == SCR_RESET) && (scratch_one_bits_ff == SCR_RESET);
    endproperty
    a_scratch_clear: assert property (p_scratch_clear)
        else $error("scratch not cleared by por or tap reset");

    property p_scratch_write;
        @(posedge core_clk_in) disable iff (reset_in || scratch_clear)
        (wr_done && hit_scr1) |=> (scratch_one_bits_ff == $past(pwdata_in[SCR_W-1:0]));
    endproperty
    a_scratch_write: assert property (p_scratch_write)
        else $error("scratch write lost");

    property p_scratch_zero_write;
        @(posedge core_clk_in) disable iff (reset_in || scratch_clear)
        (wr_done && hit_scr0) |=> (scratch_zero_bits_ff == $past(pwdata_in[SCR_W-1:0]));
    endproperty
    a_scratch_zero_write: assert property (p_scratch_zero_write)
        else $error("scratch zero write lost");

    // ordinary reset must leave scratch alone, saved firmware state survives it
    property p_scratch_keep;
        @(posedge core_clk_in) disable iff (1'b0)
        (reset_in && !scratch_clear && !wr_done) |=>
            $stable(scratch_zero_bits_ff) && $stable(scratch_one_bits_ff);
    endproperty
    a_scratch_keep: assert property (p_scratch_keep)
        else $error("scratch changed by ordinary reset");

    property p_break_only_on_write;
        @(posedge core_clk_in) disable iff (reset_in)
        !(wr_done && hit_brk && pwdata_in[BRK_BIT]) |=> !emulation_soft_break_out;
    endproperty
    a_break_only_on_write: assert property (p_break_only_on_write)
        else $error("break strobe without a break write");

    property p_dir_hold;
        @(posedge core_clk_in) disable iff (reset_in)
        !(wr_done && hit_dir) |=> $stable(port_pin_direction_out);
    endproperty
    a_dir_hold: assert property (p_dir_hold)
        else $error("direction changed without a direction write");

    // zero wait states: answer in the access cycle, gone one cycle later
    property p_bus_answer;
        @(posedge core_clk_in) disable iff (reset_in)
        setup_phase |=> (pready_out && (pslverr_out == !$past(hit_any))) ##1 !pready_out;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer missing or wrong");

    property p_read_zero_idle;
        @(posedge core_clk_in) disable iff (reset_in)
        !pready_out |-> (prdata_out == READ_ZERO);
    endproperty
    a_read_zero_idle: assert property (p_read_zero_idle)
        else $error("read data not zero outside access");

endmodule : pdr_port_debug_regs

`default_nettype wire

// ### common/pdr_pkg.sv
// package: register map, field layout and reset values of the port/debug bank
package pdr_pkg;

    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [7:0] REG_DIR_IDX = 8'h09;
    localparam logic [7:0] REG_BRK_IDX = 8'h0F;
    localparam logic [7:0] REG_SCR0_IDX = 8'h18;
    localparam logic [7:0] REG_SCR1_IDX = 8'h19;

    // field layout
    localparam int PIN_COUNT = 7;
    localparam int BRK_BIT = 0;
    localparam int SCR_W = 16;

    // reset values
    localparam logic [6:0] DIR_RESET = 7'h00;
    localparam logic BRK_RESET = 1'b0;
    localparam logic [15:0] SCR_RESET = 16'h0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage : pdr_pkg

// ### hdl/pdr_pin_drive.sv
// per-pin output driver: registered data and output enable for the port pins
`timescale 1ns/1ps
`default_nettype none

module pdr_pin_drive
    import pdr_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // control from the register bank
    input wire logic [PIN_COUNT-1:0] direction_in,
    input wire logic [PIN_COUNT-1:0] port_output_data_in,
    // pin side
    output logic [PIN_COUNT-1:0] pin_out,
    output logic [PIN_COUNT-1:0] pin_oe_out
);

    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
            // each pin sees only its own direction bit
            always_ff @(posedge core_clk_in) begin
                if (reset_in) begin
                    pin_oe_out[gi] <= 1'b0;
                    pin_out[gi] <= 1'b0;
                end else begin
                    pin_oe_out[gi] <= direction_in[gi];
                    // data parked low while released, the pad is high-z anyway
                    pin_out[gi] <= direction_in[gi] & port_output_data_in[gi];
                end
            end
        end
    endgenerate

endmodule : pdr_pin_drive

`default_nettype wire

// ### testbench/pdr_emu_model.sv
// emulation block model: counts soft-break pulses from the register bank
`timescale 1ns/1ps
`default_nettype none

module pdr_emu_model (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_in,
    // soft-break input
    input wire logic soft_break_in,
    // observation
    output logic [7:0] break_count_out
);
    // counts edges sampled high, so a stuck bit shows up as a large count
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            break_count_out <= 8'h00;
        end else if (soft_break_in) begin
            break_count_out <= break_count_out + 8'h01;
        end
    end
endmodule : pdr_emu_model

`default_nettype wire

// ### testbench/port_direction_debug_regs_tb_top.sv
// self-checking bench for the port/debug register bank
`timescale 1ns/1ps
`default_nettype none

module port_direction_debug_regs_tb_top;
    import pdr_pkg::*;
    localparam logic [7:0] A_DIR = {REG_DIR_IDX[5:0], 2'b00};
    localparam logic [7:0] A_BRK = {REG_BRK_IDX[5:0], 2'b00};
    localparam logic [7:0] A_SC0 = {REG_SCR0_IDX[5:0], 2'b00};
    localparam logic [7:0] A_SC1 = {REG_SCR1_IDX[5:0], 2'b00};
    logic core_clk_in, reset_in, por_in, tap_in, psel, penable, pwrite, pready, pslverr, brk, err;
    logic [7:0] paddr, bcnt, b0;
    logic [31:0] pwdata, prdata, rd, v, lfsr_ff;
    logic [31:0] sv [2];
    logic [6:0] pod, pin, oe, dir;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;

    pdr_port_debug_regs dut (.core_clk_in(core_clk_in), .reset_in(reset_in), .por_in(por_in),
        .tap_test_logic_reset_in(tap_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .port_output_data_in(pod),
        .port_pin_out(pin), .port_pin_oe_out(oe), .port_pin_direction_out(dir),
        .emulation_soft_break_out(brk));
    pdr_emu_model emu (.core_clk_in(core_clk_in), .reset_in(reset_in),
        .soft_break_in(brk), .break_count_out(bcnt));

    initial begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end

    function automatic logic [31:0] nxt_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt_rand

    // expected view of a direction value: seven pin bits, the rest reads zero
    function automatic logic [31:0] exp_dir(input logic [31:0] w);
        return {25'h0, w[PIN_COUNT-1:0]};
    endfunction : exp_dir

    task automatic summarize();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one idle edge first, so psel is never assigned twice in a time step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_in);
        penable <= 1'b1;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk({31'h0, pready}, 32'h1);
    endtask : apb

    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            summarize();
        end
    end

    initial begin
        {reset_in, por_in, tap_in, psel, penable, pwrite} = 6'b110000;
        paddr = 8'h00;
        pwdata = 32'h0;
        pod = 7'h00;
        lfsr_ff = 32'h0001_3C27;
        repeat (10) @(posedge core_clk_in);
        reset_in <= 1'b0;
        por_in <= 1'b0;
        apb(1'b0, A_BRK, 32'h0);
        chk(rd, READ_ZERO);
        apb(1'b0, A_SC0, 32'h0);
        chk(rd, READ_ZERO);
        for (int i = 0; i < 8; i++) begin
            lfsr_ff = nxt_rand(lfsr_ff);
            v = (i == 0) ? 32'hFFFF_FFFF : lfsr_ff;
            apb(1'b1, A_DIR, v);
            pod <= lfsr_ff[14:8];
            apb(1'b0, A_DIR, 32'h0);
            chk(rd, exp_dir(v));
            repeat (3) @(posedge core_clk_in);
            chk({25'h0, dir}, exp_dir(v));
            chk({25'h0, oe}, exp_dir(v));
            chk({25'h0, pin}, {25'h0, v[6:0] & lfsr_ff[14:8]});
        end
        b0 = bcnt;
        apb(1'b1, A_BRK, 32'hFFFF_FFFF);
        repeat (3) @(posedge core_clk_in);
        chk({24'h0, bcnt}, {24'h0, b0 + 8'h01});
        apb(1'b0, A_BRK, 32'h0);
        chk(rd, READ_ZERO);
        apb(1'b1, A_BRK, 32'hFFFF_FFFE);
        repeat (3) @(posedge core_clk_in);
        chk({24'h0, bcnt}, {24'h0, b0 + 8'h01});
        // firmware-style save of working values into scratch
        for (int k = 0; k < 2; k++) begin
            lfsr_ff = nxt_rand(lfsr_ff);
            sv[k] = lfsr_ff;
            apb(1'b1, k ? A_SC1 : A_SC0, lfsr_ff);
        end
        apb(1'b0, A_SC0, 32'h0);
        chk(rd, {16'h0, sv[0][15:0]});
        apb(1'b0, A_SC1, 32'h0);
        chk(rd, {16'h0, sv[1][15:0]});
        reset_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        reset_in <= 1'b0;
        apb(1'b0, A_DIR, 32'h0);
        chk(rd, READ_ZERO);
        apb(1'b0, A_SC0, 32'h0);
        chk(rd, {16'h0, sv[0][15:0]});
        tap_in <= 1'b1;
        @(posedge core_clk_in);
        tap_in <= 1'b0;
        apb(1'b0, A_SC1, 32'h0);
        chk(rd, READ_ZERO);
        apb(1'b1, 8'h40, 32'hFFFF_FFFF);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, READ_ZERO);
        summarize();
    end
endmodule : port_direction_debug_regs_tb_top

`default_nettype wire
